// ===== bench/split_bulk_ctrl_tt_buffer_bench.sv
// Bench: host and translator joined, plus a translator driven directly.
// Assumes package, interface and both design ends are compiled first.
`timescale 1ns/1ps
module split_bulk_ctrl_tt_buffer_bench
  import tt_pkg::*;
;
  logic       clk, rst_n, clk_en, hold_off, halt_clr, cmd_valid, cmd_ready;
  logic       cmd_dir, cmd_ctrl, cmd_setup, res_valid, halted, eof;
  logic       ds_done, ds2_done, ds_req, ds2_req, tt_en;
  logic [7:0] cmd_data, res_data, ds_data_in, ds_data_out, ds2_data;
  hs_t        res_hs;
  ds_res_t    ds_res;
  int         n_errors, tests_run, n;
  tt_link_if  la ();
  tt_link_if  lb ();

  tt_split_host tt_split_host_inst (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n),
    .CLK_EN_IN(clk_en), .CMD_VALID_IN(cmd_valid), .CMD_READY_OUT(cmd_ready),
    .CMD_ADDR_IN(7'h05), .CMD_EP_IN(4'h2), .CMD_DIR_IN(cmd_dir),
    .CMD_CTRL_IN(cmd_ctrl), .CMD_SETUP_IN(cmd_setup), .CMD_DATA_IN(cmd_data),
    .HOLD_OFF_IN(hold_off), .HALT_CLEAR_IN(halt_clr),
    .RES_VALID_OUT(res_valid), .RES_HS_OUT(res_hs), .RES_DATA_OUT(res_data),
    .HALTED_OUT(halted), .LINK(la.hc));
  tt_split_buffer tt_split_buffer_inst (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n),
    .CLK_EN_IN(tt_en), .LINK(la.tt), .DS_REQ_OUT(ds_req), .DS_ADDR_OUT(),
    .DS_EP_OUT(), .DS_DIR_OUT(), .DS_SETUP_OUT(), .DS_DATA_OUT(ds_data_out),
    .DS_DONE_IN(ds_done), .DS_RESULT_IN(ds_res), .DS_DATA_IN(ds_data_in),
    .EOF_IN(eof));
  tt_split_buffer tt_split_buffer_inst_b (.CLK_SYS_IN(clk),
    .RESET_N_IN(rst_n), .CLK_EN_IN(clk_en), .LINK(lb.tt),
    .DS_REQ_OUT(ds2_req), .DS_ADDR_OUT(), .DS_EP_OUT(), .DS_DIR_OUT(),
    .DS_SETUP_OUT(), .DS_DATA_OUT(ds2_data), .DS_DONE_IN(ds2_done),
    .DS_RESULT_IN(ds_res), .DS_DATA_IN(ds_data_in), .EOF_IN(eof));
  // Checker rests while the translator is frozen
  tt_link_chk tt_link_chk_inst (.CLK_SYS_IN(clk),
    .RESET_N_IN(rst_n && tt_en),
    .req_valid(la.req_valid), .req_kind(la.req_kind),
    .req_setup(la.req_setup), .rsp_valid(la.rsp_valid),
    .rsp_hs(la.rsp_hs), .rsp_data(la.rsp_data));

  task automatic chk(input string what, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic host_cmd(input logic dir, ctrl, setup, input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_dir <= dir;
    cmd_ctrl <= ctrl;
    cmd_setup <= setup;
    cmd_data <= d;
    @(negedge clk);
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : host_cmd

  task automatic wait_req;
    @(negedge clk);
    for (n = 0; n < 100 && ds_req !== 1'b1; n++) @(negedge clk);
  endtask : wait_req

  // Slow engine so the host sees a not-yet answer first
  task automatic ds_end(input ds_res_t r, input logic [7:0] d);
    wait_req();
    repeat (8) @(negedge clk);
    @(posedge clk);
    ds_done <= 1'b1;
    ds_res <= r;
    ds_data_in <= d;
    @(posedge clk);
    ds_done <= 1'b0;
  endtask : ds_end

  task automatic host_res(input hs_t hs);
    for (n = 0; n < 300 && res_valid !== 1'b1; n++) @(negedge clk);
    chk("result strobe", 8'h01, {7'h0, res_valid});
    chk("result code", 8'(hs), 8'(res_hs));
  endtask : host_res

  task automatic clear_halt;
    chk("halted", 8'h01, {7'h0, halted});
    repeat (20) @(posedge clk);
    halt_clr <= 1'b1;
    @(posedge clk);
    halt_clr <= 1'b0;
    repeat (2) @(negedge clk);
    chk("halt cleared", 8'h00, {7'h0, halted});
  endtask : clear_halt

  task automatic lb_req(input split_t k, input logic [3:0] ep,
                        input logic dir, ctrl, input logic [7:0] d,
                        input hs_t xhs, input logic [7:0] xd);
    @(posedge clk);
    lb.req_valid <= 1'b1;
    lb.req_kind <= k;
    lb.req_ep <= ep;
    lb.req_dir <= dir;
    lb.req_ctrl <= ctrl;
    lb.req_data <= d;
    @(posedge clk);
    lb.req_valid <= 1'b0;
    @(negedge clk);
    for (n = 0; n < 3 && lb.rsp_valid !== 1'b1; n++) @(negedge clk);
    chk("answer strobe", 8'h01, {7'h0, lb.rsp_valid});
    chk("answer code", 8'(xhs), 8'(lb.rsp_hs));
    chk("answer data", xd, lb.rsp_data);
  endtask : lb_req

  task automatic test_results;
    ds_res_t rs [4] = '{DS_ACK, DS_ACK, DS_NAK, DS_STALL};
    hs_t     hx [4] = '{HS_ACK, HS_ACK, HS_NAK, HS_STALL};
    for (int i = 0; i < 4; i++) begin
      host_cmd(i == 1, 1'b0, 1'b0, 8'h5a + 8'(i));
      wait_req();
      if (i != 1) chk("request data", 8'h5a + 8'(i), ds_data_out);
      ds_end(rs[i], 8'hc3);
      host_res(hx[i]);
      if (i == 1) chk("in data", 8'hc3, res_data);
      chk("no local retry", 8'h00, {7'h0, ds_req});
      if (i == 3) clear_halt();
    end
    $display("Result codes test done");
  endtask : test_results

  task automatic test_errors;
    host_cmd(1'b0, 1'b1, 1'b1, 8'h3c);
    ds_end(DS_ERR, 8'h00);
    wait_req();
    chk("retry after error", 8'h01, {7'h0, ds_req});
    @(posedge clk);
    eof <= 1'b1;
    @(posedge clk);
    eof <= 1'b0;
    wait_req();
    chk("retry after frame end", 8'h01, {7'h0, ds_req});
    ds_end(DS_NAK, 8'h00);
    host_res(HS_STALL);
    clear_halt();
    $display("Error retry test done");
  endtask : test_errors

  task automatic test_direct;
    lb_req(SPLIT_COMPLETE, 4'h1, 1'b0, 1'b0, 8'h00, HS_STALL, 8'h00);
    lb_req(SPLIT_START, 4'h1, 1'b0, 1'b0, 8'haa, HS_ACK, 8'h00);
    lb_req(SPLIT_START, 4'h1, 1'b0, 1'b0, 8'h55, HS_ACK, 8'h00);
    lb_req(SPLIT_START, 4'h2, 1'b0, 1'b1, 8'h11, HS_ACK, 8'h00);
    lb_req(SPLIT_START, 4'h3, 1'b0, 1'b0, 8'h22, HS_NAK, 8'h00);
    lb_req(SPLIT_COMPLETE, 4'h1, 1'b0, 1'b0, 8'h00, HS_NYET, 8'h00);
    lb_req(SPLIT_COMPLETE, 4'h2, 1'b1, 1'b1, 8'h00, HS_NYET, 8'h00);
    lb_req(SPLIT_COMPLETE, 4'h1, 1'b1, 1'b0, 8'h00, HS_STALL, 8'h00);
    chk("engine request", 8'h01, {7'h0, ds2_req});
    chk("kept first data", 8'haa, ds2_data);
    @(posedge clk);
    ds2_done <= 1'b1;
    ds_res <= DS_ACK;
    @(posedge clk);
    ds2_done <= 1'b0;
    lb_req(SPLIT_COMPLETE, 4'h1, 1'b0, 1'b0, 8'h00, HS_ACK, 8'h00);
    lb_req(SPLIT_START, 4'h3, 1'b0, 1'b0, 8'h22, HS_ACK, 8'h00);
    $display("Direct link test done");
  endtask : test_direct

  // Translator frozen after its NYET to the first complete-split, so the host times out
  task automatic test_timeout;
    @(posedge clk);
    hold_off <= 1'b1;
    host_cmd(1'b0, 1'b0, 1'b0, 8'h77);
    wait_req();
    repeat (2) @(posedge clk);
    tt_en <= 1'b0;
    repeat (100) @(negedge clk);
    chk("hold-off halted", 8'h00, {7'h0, halted});
    chk("retry kind", 8'(SPLIT_COMPLETE), 8'(la.req_kind));
    @(posedge clk);
    hold_off <= 1'b0;
    host_res(HS_STALL);
    chk("strikes halted", 8'h01, {7'h0, halted});
    $display("Timeout test done");
  endtask : test_timeout

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  initial begin
    {rst_n, hold_off, halt_clr, cmd_valid, eof, ds_done, ds2_done} = '0;
    {cmd_dir, cmd_ctrl, cmd_setup, cmd_data, ds_data_in} = '0;
    clk_en = 1'b1;
    tt_en = 1'b1;
    ds_res = DS_ACK;
    n_errors = 0;
    tests_run = 0;
    lb.req_valid = 1'b0;
    lb.req_kind = SPLIT_START;
    lb.req_addr = 7'h03;
    {lb.req_ep, lb.req_dir, lb.req_ctrl, lb.req_setup, lb.req_data} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    test_results();
    test_errors();
    test_direct();
    test_timeout();
    stop_test();
  end
endmodule : split_bulk_ctrl_tt_buffer_bench

// ===== bench/tt_link_chk.sv
// Link checker for the host and translator pair.
// Assumes one clock domain; reset input held low while a side is frozen.
`timescale 1ns/1ps
`include "tt_params.svh"
module tt_link_chk
  import tt_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLK_SYS_IN,
  input  wire logic                  RESET_N_IN,
  // Link signals
  input  wire logic                  req_valid,
  input  wire split_t                req_kind,
  input  wire logic                  req_setup,
  input  wire logic                  rsp_valid,
  input  wire hs_t                   rsp_hs,
  input  wire logic [`TT_DATA_W-1:0] rsp_data
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);

  property p_rsp_next;
    req_valid |=> rsp_valid;
  endproperty
  a_rsp_next: assert property (p_rsp_next)
    else $error("request left unanswered");
  property p_rsp_cause;
    rsp_valid |-> $past(req_valid);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause)
    else $error("answer without request");
  property p_ss_hs;
    req_valid && req_kind == SPLIT_START |=> rsp_hs inside {HS_ACK, HS_NAK};
  endproperty
  a_ss_hs: assert property (p_ss_hs)
    else $error("bad start answer");
  property p_cs_hs;
    req_valid && req_kind == SPLIT_COMPLETE |=>
      rsp_hs inside {HS_ACK, HS_NAK, HS_NYET, HS_STALL};
  endproperty
  a_cs_hs: assert property (p_cs_hs)
    else $error("bad complete answer");
  property p_no_data;
    rsp_valid && rsp_hs != HS_ACK |-> rsp_data == 8'h00;
  endproperty
  a_no_data: assert property (p_no_data)
    else $error("data without ack");
  property p_hs_hold;
    !rsp_valid |-> $stable(rsp_hs);
  endproperty
  a_hs_hold: assert property (p_hs_hold)
    else $error("answer code moved");
  property p_setup_nak;
    rsp_valid && rsp_hs == HS_NAK && req_kind == SPLIT_COMPLETE |-> !req_setup;
  endproperty
  a_setup_nak: assert property (p_setup_nak)
    else $error("setup gave nak");
  property p_stall_halt;
    rsp_valid && rsp_hs == HS_STALL && req_kind == SPLIT_COMPLETE |=>
      !req_valid [*8];
  endproperty
  a_stall_halt: assert property (p_stall_halt)
    else $error("request after stall");
  property p_ack_cs;
    rsp_valid && rsp_hs == HS_ACK && req_kind == SPLIT_START |->
      ##[1:4] (req_valid && req_kind == SPLIT_COMPLETE);
  endproperty
  a_ack_cs: assert property (p_ack_cs)
    else $error("no complete after ack");
  property p_nyet_retry;
    rsp_valid && rsp_hs == HS_NYET |->
      ##[1:12] (req_valid && req_kind == SPLIT_COMPLETE);
  endproperty
  a_nyet_retry: assert property (p_nyet_retry)
    else $error("no retry after nyet");

  c_nyet: cover property (rsp_valid && rsp_hs == HS_NYET);
  c_stall: cover property (rsp_valid && rsp_hs == HS_STALL);
  c_ack_data: cover property (rsp_valid && rsp_data != 8'h00);
endmodule : tt_link_chk

// ===== rtl/tt_link_if.sv
// High-speed split link between host controller and translator.
// One request pulse, answered by one response pulse; same clock both ends.
`timescale 1ns/1ps
`include "tt_params.svh"
interface tt_link_if;
  import tt_pkg::*;
  logic                  req_valid;
  split_t                req_kind;
  logic [6:0]            req_addr;
  logic [3:0]            req_ep;
  logic                  req_dir;
  logic                  req_ctrl;
  logic                  req_setup;
  logic [`TT_DATA_W-1:0] req_data;
  logic                  rsp_valid;
  hs_t                   rsp_hs;
  logic [`TT_DATA_W-1:0] rsp_data;
  modport hc (
    output req_valid, req_kind, req_addr, req_ep, req_dir, req_ctrl,
    output req_setup, req_data,
    input  rsp_valid, rsp_hs, rsp_data
  );
  modport tt (
    input  req_valid, req_kind, req_addr, req_ep, req_dir, req_ctrl,
    input  req_setup, req_data,
    output rsp_valid, rsp_hs, rsp_data
  );
endinterface : tt_link_if

// ===== rtl/tt_params.svh
// Shared constants for the split bulk/control transaction translator.
// Assumes both ends run on one 50 MHz system clock.
`ifndef TT_PARAMS_SVH
`define TT_PARAMS_SVH
`define TT_NUM_BUFS        2
`define TT_ERR_LIMIT       3
`define TT_DATA_W          8
`define TT_CLK_PERIOD_NS   20
`define TT_RSP_TIMEOUT_NS  400
`define TT_RSP_TIMEOUT_CYC ((`TT_RSP_TIMEOUT_NS + `TT_CLK_PERIOD_NS - 1) / `TT_CLK_PERIOD_NS)
`define TT_CS_GAP_CYC      4
`endif

// ===== rtl/tt_pkg.sv
// Types shared by the host end, the translator end and the link.
// Assumes tt_params.svh is on the include path.
`include "tt_params.svh"
package tt_pkg;
  typedef enum logic [2:0] {
    HS_NONE, HS_ACK, HS_NAK, HS_NYET, HS_STALL
  } hs_t;
  typedef enum logic [1:0] {
    DS_ACK, DS_NAK, DS_STALL, DS_ERR
  } ds_res_t;
  typedef enum logic [1:0] {
    BUF_OLD, BUF_PENDING, BUF_READY
  } buf_stat_t;
  typedef enum logic {
    SPLIT_START, SPLIT_COMPLETE
  } split_t;
  typedef struct packed {
    buf_stat_t               stat;
    logic                    used;
    logic [6:0]              addr;
    logic [3:0]              ep;
    logic                    dir;
    logic                    ctrl;
    logic                    setup;
    logic [`TT_DATA_W-1:0]   data;
    hs_t                     result;
  } buf_t;
endpackage : tt_pkg

// ===== rtl/tt_split_buffer.sv
// Translator end: buffers bulk/control splits, runs them downstream.
// Assumes the link and downstream engine share CLK_SYS_IN.
`timescale 1ns/1ps
`include "tt_params.svh"
// Summary of operation
// - Record nak, stall or ack result
// - Retry errors locally; three errors give stall
// - Never retry after ACK, NAK, STALL; here a NAK to setup is retried as an error
// - Complete-split on pending buffer answers NYET
// - Complete-split without matching buffer answers STALL
// - Downstream finish stores result, pending to ready
// - Served ready buffer moves to old
// - Stored start-split answered with ACK
// - Issue downstream promptly, store handshake and data
// - Ready buffer returns stored data and handshake
// - Host retries failed complete-split at once
// - Host ignores memory hold-off for errors
// - Host halts endpoint on STALL
// - Host records ACK result, moves on
// - Host reissues start-split after NAK; here the NAK goes back to the scheduler and the host returns to idle
// - Host retries start-split until three errors
// - Host may then start-split any free endpoint; here it takes no command until HALT_CLEAR_IN
// - Setup never yields a NAK result
// - Host issues no other bulk split first
// - End of frame counts as transaction error
// - Match address, endpoint, direction unless control
// - No free buffer answers NAK
// - Retried start-split gets ACK, data dropped
module tt_split_buffer
  import tt_pkg::*;
#(
  parameter int NUM_BUFS  = `TT_NUM_BUFS,
  parameter int ERR_LIMIT = `TT_ERR_LIMIT
) (
  // Clock, reset, enable
  input  wire logic                  CLK_SYS_IN,
  input  wire logic                  RESET_N_IN,
  input  wire logic                  CLK_EN_IN,
  // High-speed link
  tt_link_if.tt                      LINK,
  // Downstream engine request
  output logic                       DS_REQ_OUT,
  output logic [6:0]                 DS_ADDR_OUT,
  output logic [3:0]                 DS_EP_OUT,
  output logic                       DS_DIR_OUT,
  output logic                       DS_SETUP_OUT,
  output logic [`TT_DATA_W-1:0]      DS_DATA_OUT,
  // Downstream engine result
  input  wire logic                  DS_DONE_IN,
  input  wire ds_res_t               DS_RESULT_IN,
  input  wire logic [`TT_DATA_W-1:0] DS_DATA_IN,
  input  wire logic                  EOF_IN
);
  localparam int IW = (NUM_BUFS > 1) ? $clog2(NUM_BUFS) : 1;

  typedef enum logic [1:0] {DS_IDLE, DS_RUN, DS_RETRY} ds_st_t;

  typedef struct packed {
    logic            hit;
    logic [IW-1:0]   hit_idx;
    logic            free;
    logic [IW-1:0]   free_idx;
  } cmp_t;

  typedef struct packed {
    buf_t [NUM_BUFS-1:0]   bufs;
    logic                  rsp_valid;
    hs_t                   rsp_hs;
    logic [`TT_DATA_W-1:0] rsp_data;
    ds_st_t                ds_st;
    logic [IW-1:0]         cur;
    logic [1:0]            tries;
    logic                  ds_req;
    logic [6:0]            ds_addr;
    logic [3:0]            ds_ep;
    logic                  ds_dir;
    logic                  ds_setup;
    logic [`TT_DATA_W-1:0] ds_data;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // match on address, endpoint, direction unless control
  function automatic cmp_t compare_bufs(input buf_t [NUM_BUFS-1:0] b,
                                        input logic [6:0] addr,
                                        input logic [3:0] ep,
                                        input logic dir,
                                        input logic ctrl);
    cmp_t c;
    c = '0;
    for (int i = NUM_BUFS - 1; i >= 0; i--) begin
      if (b[i].used && b[i].addr == addr && b[i].ep == ep &&
          (ctrl || b[i].dir == dir)) begin
        c.hit     = 1'b1;
        c.hit_idx = IW'(i);
      end
      if (b[i].stat == BUF_OLD) begin
        c.free     = 1'b1;
        c.free_idx = IW'(i);
      end
    end
    return c;
  endfunction : compare_bufs

  function automatic hs_t map_result(input ds_res_t r);
    hs_t h;
    h = HS_STALL;
    if (r == DS_ACK) begin
      h = HS_ACK;
    end else if (r == DS_NAK) begin
      h = HS_NAK;
    end
    return h;
  endfunction : map_result

  always_comb begin
    cmp_t          m;
    logic          found;
    logic [IW-1:0] pick;
    logic          err;
    m          = '0;
    found      = 1'b0;
    pick       = '0;
    err        = 1'b0;
    state_next = state_reg;
    state_next.rsp_valid = 1'b0;
    if (LINK.req_valid) begin
      m = compare_bufs(state_reg.bufs, LINK.req_addr, LINK.req_ep,
                       LINK.req_dir, LINK.req_ctrl);
      state_next.rsp_valid = 1'b1;
      state_next.rsp_data  = '0;
      if (LINK.req_kind == SPLIT_START) begin
        if (m.hit && state_reg.bufs[m.hit_idx].stat != BUF_OLD) begin
          state_next.rsp_hs = HS_ACK;
        end else if (m.hit || m.free) begin
          pick = m.hit ? m.hit_idx : m.free_idx;
          state_next.bufs[pick].stat   = BUF_PENDING;
          state_next.bufs[pick].used   = 1'b1;
          state_next.bufs[pick].addr   = LINK.req_addr;
          state_next.bufs[pick].ep     = LINK.req_ep;
          state_next.bufs[pick].dir    = LINK.req_dir;
          state_next.bufs[pick].ctrl   = LINK.req_ctrl;
          state_next.bufs[pick].setup  = LINK.req_setup;
          state_next.bufs[pick].data   = LINK.req_data;
          state_next.bufs[pick].result = HS_NONE;
          state_next.rsp_hs = HS_ACK;
        end else begin
          state_next.rsp_hs = HS_NAK;
        end
      end else if (!m.hit) begin
        state_next.rsp_hs = HS_STALL;
      end else if (state_reg.bufs[m.hit_idx].stat == BUF_PENDING) begin
        state_next.rsp_hs = HS_NYET;
      end else begin
        state_next.rsp_hs   = state_reg.bufs[m.hit_idx].result;
        state_next.rsp_data = state_reg.bufs[m.hit_idx].dir ?
                              state_reg.bufs[m.hit_idx].data : '0;
        // ready to old, result kept for replay
        state_next.bufs[m.hit_idx].stat = BUF_OLD;
      end
    end

    case (state_reg.ds_st)
      DS_IDLE: begin
        for (int i = NUM_BUFS - 1; i >= 0; i--) begin
          if (state_reg.bufs[i].stat == BUF_PENDING) begin
            found = 1'b1;
            pick  = IW'(i);
          end
        end
        // issue the lowest pending index as soon as possible
        if (found) begin
          state_next.cur      = pick;
          state_next.tries    = 2'h0;
          state_next.ds_req   = 1'b1;
          state_next.ds_addr  = state_reg.bufs[pick].addr;
          state_next.ds_ep    = state_reg.bufs[pick].ep;
          state_next.ds_dir   = state_reg.bufs[pick].dir;
          state_next.ds_setup = state_reg.bufs[pick].setup;
          state_next.ds_data  = state_reg.bufs[pick].data;
          state_next.ds_st    = DS_RUN;
        end
      end
      DS_RUN: begin
        if (EOF_IN) begin
          // frame end aborts, counted as error
          err = 1'b1;
        end else if (DS_DONE_IN) begin
          // a NAK to setup is treated as a bus error
          if (DS_RESULT_IN == DS_ERR ||
              (DS_RESULT_IN == DS_NAK && state_reg.ds_setup)) begin
            err = 1'b1;
          end else begin
            // handshake ends the transaction, no retry
            state_next.bufs[state_reg.cur].result =
              map_result(DS_RESULT_IN);
            if (state_reg.ds_dir && DS_RESULT_IN == DS_ACK) begin
              state_next.bufs[state_reg.cur].data = DS_DATA_IN;
            end
            state_next.bufs[state_reg.cur].stat = BUF_READY;
            state_next.ds_req = 1'b0;
            state_next.ds_st  = DS_IDLE;
          end
        end
        if (err) begin
          state_next.ds_req = 1'b0;
          if (32'(state_reg.tries) + 1 >= ERR_LIMIT) begin
            state_next.bufs[state_reg.cur].result = HS_STALL;
            state_next.bufs[state_reg.cur].stat   = BUF_READY;
            state_next.ds_st = DS_IDLE;
          end else begin
            state_next.tries = state_reg.tries + 2'h1;
            state_next.ds_st = DS_RETRY;
          end
        end
      end
      DS_RETRY: begin
        // Request drops one cycle so the engine sees a fresh edge
        state_next.ds_req = 1'b1;
        state_next.ds_st  = DS_RUN;
      end
      default: begin
        state_next.ds_st = DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      // every buffer starts old and unused
      state_reg <= '0;
    end else if (CLK_EN_IN) begin
      state_reg <= state_next;
    end
  end

  assign LINK.rsp_valid = state_reg.rsp_valid;
  assign LINK.rsp_hs    = state_reg.rsp_hs;
  assign LINK.rsp_data  = state_reg.rsp_data;
  assign DS_REQ_OUT     = state_reg.ds_req;
  assign DS_ADDR_OUT    = state_reg.ds_addr;
  assign DS_EP_OUT      = state_reg.ds_ep;
  assign DS_DIR_OUT     = state_reg.ds_dir;
  assign DS_SETUP_OUT   = state_reg.ds_setup;
  assign DS_DATA_OUT    = state_reg.ds_data;
endmodule : tt_split_buffer

// ===== rtl/tt_split_host.sv
// Host controller end: one bulk/control split sequence at a time.
// Assumes the translator end answers on the same clock.
`timescale 1ns/1ps
`include "tt_params.svh"
module tt_split_host
  import tt_pkg::*;
#(
  parameter int ERR_LIMIT   = `TT_ERR_LIMIT,
  parameter int TIMEOUT_CYC = `TT_RSP_TIMEOUT_CYC,
  parameter int CS_GAP_CYC  = `TT_CS_GAP_CYC
) (
  // Clock, reset, enable
  input  wire logic                  CLK_SYS_IN,
  input  wire logic                  RESET_N_IN,
  input  wire logic                  CLK_EN_IN,
  // Command from scheduler
  input  wire logic                  CMD_VALID_IN,
  output logic                       CMD_READY_OUT,
  input  wire logic [6:0]            CMD_ADDR_IN,
  input  wire logic [3:0]            CMD_EP_IN,
  input  wire logic                  CMD_DIR_IN,
  input  wire logic                  CMD_CTRL_IN,
  input  wire logic                  CMD_SETUP_IN,
  input  wire logic [`TT_DATA_W-1:0] CMD_DATA_IN,
  input  wire logic                  HOLD_OFF_IN,
  input  wire logic                  HALT_CLEAR_IN,
  // Result to scheduler
  output logic                       RES_VALID_OUT,
  output hs_t                        RES_HS_OUT,
  output logic [`TT_DATA_W-1:0]      RES_DATA_OUT,
  output logic                       HALTED_OUT,
  // High-speed link
  tt_link_if.hc                      LINK
);
  typedef enum logic [2:0] {
    H_IDLE, H_SS_WAIT, H_CS_WAIT, H_GAP
  } host_st_t;

  typedef struct packed {
    host_st_t              st;
    logic                  cmd_ready;
    logic                  req_valid;
    split_t                kind;
    logic [6:0]            addr;
    logic [3:0]            ep;
    logic                  dir;
    logic                  ctrl;
    logic                  setup;
    logic [`TT_DATA_W-1:0] data;
    logic [1:0]            err;
    logic [7:0]            tmr;
    logic                  halted;
    logic                  res_valid;
    hs_t                   res_hs;
    logic [`TT_DATA_W-1:0] res_data;
  } state_t;

  state_t state_reg;
  state_t state_next;

  always_comb begin
    state_next           = state_reg;
    state_next.req_valid = 1'b0;
    state_next.res_valid = 1'b0;
    state_next.tmr       = state_reg.tmr + 8'h01;
    if (HALT_CLEAR_IN) begin
      state_next.halted = 1'b0;
    end
    case (state_reg.st)
      H_IDLE: begin
        if (CMD_VALID_IN && state_reg.cmd_ready) begin
          state_next.addr      = CMD_ADDR_IN;
          state_next.ep        = CMD_EP_IN;
          state_next.dir       = CMD_DIR_IN;
          state_next.ctrl      = CMD_CTRL_IN;
          state_next.setup     = CMD_SETUP_IN;
          state_next.data      = CMD_DATA_IN;
          state_next.err       = 2'h0;
          state_next.kind      = SPLIT_START;
          state_next.req_valid = 1'b1;
          state_next.tmr       = 8'h00;
          state_next.st        = H_SS_WAIT;
        end
      end
      H_SS_WAIT, H_CS_WAIT: begin
        if (LINK.rsp_valid && (LINK.rsp_hs == HS_ACK) &&
            state_reg.st == H_SS_WAIT) begin
          state_next.kind      = SPLIT_COMPLETE;
          state_next.req_valid = 1'b1;
          state_next.tmr       = 8'h00;
          state_next.st        = H_CS_WAIT;
        end else if (LINK.rsp_valid && LINK.rsp_hs == HS_NYET &&
                     state_reg.st == H_CS_WAIT) begin
          state_next.tmr = 8'h00;
          state_next.st  = H_GAP;
        end else if (LINK.rsp_valid &&
                     (LINK.rsp_hs == HS_ACK || LINK.rsp_hs == HS_NAK ||
                      LINK.rsp_hs == HS_STALL)) begin
          // NAK handed back for a later reissue
          state_next.res_valid = 1'b1;
          state_next.res_hs    = LINK.rsp_hs;
          state_next.res_data  = LINK.rsp_data;
          state_next.err       = 2'h0;
          state_next.halted    = (LINK.rsp_hs == HS_STALL);
          state_next.st        = H_IDLE;
        end else if (LINK.rsp_valid ||
                     32'(state_reg.tmr) + 1 >= TIMEOUT_CYC) begin
          // bad or missing answer, reissue at once
          state_next.req_valid = 1'b1;
          state_next.tmr       = 8'h00;
          if (!HOLD_OFF_IN) begin
            state_next.err = state_reg.err + 2'h1;
            if (32'(state_reg.err) + 1 >= ERR_LIMIT) begin
              state_next.req_valid = 1'b0;
              state_next.halted    = 1'b1;
              state_next.res_valid = 1'b1;
              state_next.res_hs    = HS_STALL;
              state_next.st        = H_IDLE;
            end
          end
        end
      end
      H_GAP: begin
        // nothing else queued while the complete-split is owed
        if (32'(state_reg.tmr) + 1 >= CS_GAP_CYC) begin
          state_next.req_valid = 1'b1;
          state_next.tmr       = 8'h00;
          state_next.st        = H_CS_WAIT;
        end
      end
      default: begin
        state_next.st = H_IDLE;
      end
    endcase
    // next command accepted once answer resolved and no halt is set
    state_next.cmd_ready = (state_next.st == H_IDLE) && !state_next.halted;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_reg <= '0;
    end else if (CLK_EN_IN) begin
      state_reg <= state_next;
    end
  end

  assign CMD_READY_OUT  = state_reg.cmd_ready;
  assign RES_VALID_OUT  = state_reg.res_valid;
  assign RES_HS_OUT     = state_reg.res_hs;
  assign RES_DATA_OUT   = state_reg.res_data;
  assign HALTED_OUT     = state_reg.halted;
  assign LINK.req_valid = state_reg.req_valid;
  assign LINK.req_kind  = state_reg.kind;
  assign LINK.req_addr  = state_reg.addr;
  assign LINK.req_ep    = state_reg.ep;
  assign LINK.req_dir   = state_reg.dir;
  assign LINK.req_ctrl  = state_reg.ctrl;
  assign LINK.req_setup = state_reg.setup;
  assign LINK.req_data  = state_reg.data;
endmodule : tt_split_host
